// ### verilog/cad_dev.sv
// Address decoder and discrete port logic of the controller CPU board.
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`default_nettype none
module cad_dev
    import cad_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    cad_bus_if.dev bus, // Decoder bus from the microcontroller.
    input wire logic [63:0] in_pin_n, // Discrete inputs, low means true.
    input wire logic [7:0] ext_rdata, // Data from selected memory or UART.
    input wire logic [7:0] dta_minutes, // Downtime accumulator minutes.
    input wire logic [7:0] downtime_seconds, // Downtime accumulator seconds.
    input wire logic acc_overflow, // Accumulator overflow flag.
    input wire logic uart_irq, // Serial port interrupt.
    input wire logic rtc_irq, // Clock interrupt.
    output cad_region_e mem_region, // Region the current address hits.
    output logic [16:0] prom_addr, // PROM address with page bit on top.
    output logic [3:0] uart_sel, // One-hot serial port window select.
    output logic [2:0] uart_reg, // Register index within the window.
    output logic rtc_sel, // Clock register select.
    output logic rtc_reset, // Clock reset pulse.
    output logic orient_restart, // Orientation timer restart pulse.
    output logic dta_clear, // Downtime accumulator clear pulse.
    output logic [79:0] out_pin_o, // Open-collector pin level, always low.
    output logic [79:0] out_pin_oe // Pin sink enable, high grounds it.
);
    typedef struct packed {
        cad_region_e region;
        logic [16:0] prom_addr;
        logic [3:0] uart_sel;
        logic [2:0] uart_reg;
        logic rtc_sel;
        logic rtc_reset;
        logic orient_restart;
        logic dta_clear;
        logic [CAD_OUT_PORTS-1:0][7:0] out_latch;
        logic [7:0] rdata;
        logic ack;
    } cad_dev_s;

    cad_dev_s s;
    cad_dev_s next_s;

    // Region of an address under the given large-RAM bank level.
    function automatic cad_region_e region_of(input logic [15:0] a, input logic big_ram);
        cad_region_e r;
        r = CAD_RG_NONE;
        if (a[15]) begin
            r = CAD_RG_PROM;
        end else if (a <= CAD_NVRAM_MID_END) begin
            if (big_ram || a <= CAD_NVRAM_LO_END || a > CAD_PROM_LO_END) begin
                r = CAD_RG_NVRAM;
            end else begin
                r = CAD_RG_PROM;
            end
        end else if (a <= CAD_MCU_REG_END) begin
            r = CAD_RG_MCU;
        end else if (a <= CAD_CPU_RAM_END) begin
            r = CAD_RG_CPU_RAM;
        end else if (a <= CAD_IO_END) begin
            r = CAD_RG_IO;
        end else begin
            r = CAD_RG_NVRAM;
        end
        return r;
    endfunction

    // Port index for an address among count ports, or count when none.
    function automatic int port_of(input logic [15:0] a, input int count);
        int p;
        p = count;
        if (a >= CAD_PORT_FIRST && a < CAD_PORT_FIRST + 16'(count)) begin
            p = int'(a - CAD_PORT_FIRST);
        end
        return p;
    endfunction

    // True when an address lies inside a closed range.
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
        input logic [15:0] hi);
        return a >= lo && a <= hi;
    endfunction

    cad_region_e cur_region;
    logic in_uart;
    logic [7:0] status_byte;
    logic [7:0] read_byte;
    int out_idx;
    int in_idx;
    logic [CAD_IN_PORTS-1:0][7:0] in_true;

    // Open inputs sit at the pull-up level, so they read as zero.
    // grounded input reads as one
    assign in_true = ~in_pin_n;

    assign cur_region = region_of(bus.addr, bus.bank2);
    assign in_uart = (cur_region == CAD_RG_IO)
        && in_range(bus.addr, CAD_UART_BASE, CAD_UART_END);
    assign out_idx = port_of(bus.addr, CAD_OUT_PORTS);
    assign in_idx = port_of(bus.addr, CAD_IN_PORTS);

    always_comb begin
        status_byte = 8'h00;
        status_byte[CAD_ST_UART] = uart_irq;
        status_byte[CAD_ST_BANK2] = bus.bank2;
        status_byte[CAD_ST_BANK1] = bus.bank1;
        status_byte[CAD_ST_OVF] = acc_overflow;
        status_byte[CAD_ST_RTC] = rtc_irq;
    end

    always_comb begin
        read_byte = 8'h00;
        if (cur_region != CAD_RG_IO && cur_region != CAD_RG_NONE) begin
            read_byte = ext_rdata;
        end else if (in_uart) begin
            read_byte = ext_rdata;
        end else if (bus.addr == CAD_DTA_MIN) begin
            read_byte = dta_minutes;
        end else if (bus.addr == CAD_DTA_SEC) begin
            read_byte = downtime_seconds;
        end else if (bus.addr == CAD_IRQ_STATUS) begin
            read_byte = status_byte;
        // Ports 7409 and 740A are output only, so reads there fall through to zero.
        end else if (in_idx < CAD_IN_PORTS) begin
            read_byte = in_true[in_idx];
        end
    end

    always_comb begin
        next_s = s;
        next_s.rtc_reset = 1'b0;
        next_s.orient_restart = 1'b0;
        next_s.dta_clear = 1'b0;
        // Every strobe is answered, holes in the map included, so the host never hangs.
        next_s.ack = bus.rd || bus.wr;
        next_s.region = cur_region;
        next_s.prom_addr = {bus.bank1, bus.addr};
        next_s.uart_sel = 4'h0;
        next_s.uart_reg = bus.addr[2:0];
        // The windows lie back to back, so address bits 4:3 pick the port.
        if (in_uart) begin
            next_s.uart_sel[bus.addr[4:3]] = 1'b1;
        end
        // Selects follow the address on every cycle, not only under a strobe, so a
        // consumer must qualify them with its own strobe before acting on them.
        // clock registers at top of RAM
        next_s.rtc_sel = in_range(bus.addr, CAD_RTC_BASE, CAD_NVRAM_HI_END);
        if (bus.wr && cur_region == CAD_RG_IO) begin
            if (out_idx < CAD_OUT_PORTS) begin
                next_s.out_latch[out_idx] = bus.wdata;
            end
            if (bus.addr == CAD_DTA_MIN) begin
                next_s.dta_clear = 1'b1;
            end
            if (bus.addr == CAD_IRQ_STATUS) begin
                next_s.rtc_reset = 1'b1;
            end
        end
        if (bus.rd) begin
            next_s.rdata = read_byte;
            // Any read of this port restarts the timer, whichever bit software uses.
            // orientation restart side effect
            if (bus.addr == CAD_ORIENT) begin
                next_s.orient_restart = 1'b1;
            end
        end
    end

    // latches change only on their own write or at reset.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Power loss is treated as this reset, so every latch opens with it.
            // all outputs open at reset
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign mem_region = s.region;
    assign prom_addr = s.prom_addr;
    assign uart_sel = s.uart_sel;
    assign uart_reg = s.uart_reg;
    assign rtc_sel = s.rtc_sel;
    assign rtc_reset = s.rtc_reset;
    assign orient_restart = s.orient_restart;
    assign dta_clear = s.dta_clear;
    // a one sinks the pin, zero floats
    assign out_pin_oe = s.out_latch;
    // The pin level stays low; only the enable chooses between sink and open.
    assign out_pin_o = '0;
    assign bus.rdata = s.rdata;
    assign bus.ack = s.ack;
endmodule
`default_nettype wire

// ### verilog/cad_pkg.sv
// Constants, types and the memory map shared by both ends of the decoder bus.
// Summary of operation
// - Bank one comes from port bit 0.
// - Bank two comes from port bit 1.
// - After reset bank one high, bank two low.
// - Fixed map for registers, CPU RAM, high nonvolatile_ram.
// - Bank two selects large or split RAM layout.
// - Upper half is PROM, bank one pages.
// - I/O region 7400-75FF in every layout.
// - Reading 7404 restarts the orientation timer.
// - Four 8-byte serial port windows from 7420.
// - Reading 75FF returns interrupt status.
// - Status byte bit layout with banks, flags.
// - Clock registers at 7FF8-7FFF.
// - Discrete inputs and outputs are ground-true.
// - Transfers move whole bytes.
// - Read/write command steers transfer direction.
// - Eighty output bits in byte ports.
// - Output port latches on write.
// - One grounds the pin, zero leaves open.
// - Output port holds until rewritten.
// - Output latches clear at reset.
// - Read returns one for grounded inputs.
`default_nettype none
package cad_pkg;
    localparam logic [15:0] CAD_NVRAM_LO_END = 16'h1FFF;
    localparam logic [15:0] CAD_PROM_LO_END = 16'h5FFF;
    localparam logic [15:0] CAD_NVRAM_MID_END = 16'h6FFF;
    localparam logic [15:0] CAD_MCU_REG_END = 16'h705F;
    localparam logic [15:0] CAD_CPU_RAM_END = 16'h73FF;
    localparam logic [15:0] CAD_IO_END = 16'h75FF;
    localparam logic [15:0] CAD_NVRAM_HI_END = 16'h7FFF;
    localparam logic [15:0] CAD_RTC_BASE = 16'h7FF8;
    localparam logic [15:0] CAD_DTA_MIN = 16'h7400;
    localparam logic [15:0] CAD_PORT_FIRST = 16'h7401;
    localparam logic [15:0] CAD_ORIENT = 16'h7404;
    localparam logic [15:0] CAD_DTA_SEC = 16'h740F;
    localparam logic [15:0] CAD_UART_BASE = 16'h7420;
    localparam logic [15:0] CAD_UART_END = 16'h743F;
    localparam logic [15:0] CAD_IRQ_STATUS = 16'h75FF;
    localparam int CAD_OUT_PORTS = 10;
    localparam int CAD_IN_PORTS = 8;
    // Status byte positions, counted from zero.
    localparam int CAD_ST_UART = 0;
    localparam int CAD_ST_BANK2 = 4;
    localparam int CAD_ST_BANK1 = 5;
    localparam int CAD_ST_OVF = 6;
    localparam int CAD_ST_RTC = 7;
    localparam logic CAD_BANK1_RESET = 1'b1;
    localparam logic CAD_BANK2_RESET = 1'b0;
    // Host register byte addresses on AHB-Lite.
    localparam logic [7:0] CAD_HR_ADDR = 8'h00;
    localparam logic [7:0] CAD_HR_WDATA = 8'h04;
    localparam logic [7:0] CAD_HR_CTRL = 8'h08;
    localparam logic [7:0] CAD_HR_STATUS = 8'h0C;
    localparam logic [7:0] CAD_HR_BANK = 8'h10;
    localparam int CAD_CTRL_GO = 0;
    localparam int CAD_CTRL_WRITE = 1;
    typedef enum logic [2:0] {
        CAD_RG_NONE, CAD_RG_NVRAM, CAD_RG_PROM, CAD_RG_MCU, CAD_RG_CPU_RAM, CAD_RG_IO
    } cad_region_e;
endpackage
`default_nettype wire

// ### verilog/cad_bus_if.sv
// Byte-wide bus between the microcontroller end and the address decoder.
`default_nettype none
interface cad_bus_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
    logic bank1;
    logic bank2;
    logic [7:0] rdata;
    logic ack;
    modport host (output addr, output wdata, output rd, output wr, output bank1,
        output bank2, input rdata, input ack);
    modport dev (input addr, input wdata, input rd, input wr, input bank1,
        input bank2, output rdata, output ack);
endinterface
`default_nettype wire

// ### verilog/cad_host.sv
// Microcontroller end: AHB-Lite command registers driving the decoder bus.
`default_nettype none
module cad_host
    import cad_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic hsel, // AHB slave select.
    input wire logic [31:0] haddr, // AHB address.
    input wire logic [1:0] htrans, // AHB transfer type.
    input wire logic hwrite, // AHB write.
    input wire logic [2:0] hsize, // AHB size, word only.
    input wire logic [31:0] hwdata, // AHB write data.
    input wire logic hready, // AHB bus ready.
    output logic [31:0] hrdata, // AHB read data.
    output logic hreadyout, // AHB slave ready.
    output logic hresp, // AHB response, always OKAY.
    cad_bus_if.host bus // Decoder bus.
);
    typedef struct packed {
        logic [15:0] cmd_addr;
        logic [7:0] cmd_wdata;
        logic [7:0] cmd_rdata;
        logic [1:0] bank;
        logic busy;
        logic is_write;
        logic done;
        logic wr_pend;
        logic [7:0] wr_off;
        logic [31:0] hrdata;
        logic [15:0] b_addr;
        logic [7:0] b_wdata;
        logic b_rd;
        logic b_wr;
    } cad_host_s;

    cad_host_s s;
    cad_host_s next_s;
    logic take;

    assign take = hsel && htrans[1] && hready;

    always_comb begin
        next_s = s;
        next_s.b_rd = 1'b0;
        next_s.b_wr = 1'b0;
        next_s.wr_pend = take && hwrite;
        if (take) begin
            next_s.wr_off = haddr[7:0];
        end
        if (take && !hwrite) begin
            unique case (haddr[7:0])
                CAD_HR_ADDR: next_s.hrdata = {16'h0000, s.cmd_addr};
                CAD_HR_WDATA: next_s.hrdata = {24'h000000, s.cmd_wdata};
                CAD_HR_STATUS: next_s.hrdata = {16'h0000, s.cmd_rdata, 6'h00, s.done, s.busy};
                CAD_HR_BANK: next_s.hrdata = {30'h0, s.bank};
                default: next_s.hrdata = 32'h00000000;
            endcase
        end
        if (s.busy && bus.ack) begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
            if (!s.is_write) begin
                next_s.cmd_rdata = bus.rdata;
            end
        end
        if (s.wr_pend) begin
            unique case (s.wr_off)
                CAD_HR_ADDR: next_s.cmd_addr = hwdata[15:0];
                CAD_HR_WDATA: next_s.cmd_wdata = hwdata[7:0];
                CAD_HR_BANK: next_s.bank = hwdata[1:0];
                CAD_HR_CTRL: begin
                    if (hwdata[CAD_CTRL_GO] && !s.busy) begin
                        next_s.busy = 1'b1;
                        next_s.done = 1'b0;
                        next_s.is_write = hwdata[CAD_CTRL_WRITE];
                        next_s.b_addr = s.cmd_addr;
                        next_s.b_wdata = s.cmd_wdata;
                        next_s.b_rd = !hwdata[CAD_CTRL_WRITE];
                        next_s.b_wr = hwdata[CAD_CTRL_WRITE];
                    end
                end
                default: next_s.busy = next_s.busy;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.bank <= {CAD_BANK2_RESET, CAD_BANK1_RESET};
        end else begin
            s <= next_s;
        end
    end

    assign hrdata = s.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bus.addr = s.b_addr;
    assign bus.wdata = s.b_wdata;
    assign bus.rd = s.b_rd;
    assign bus.wr = s.b_wr;
    assign bus.bank1 = s.bank[0];
    assign bus.bank2 = s.bank[1];
endmodule
`default_nettype wire

// ### tb/cad_bus_sva.sv
// Concurrent checks on the decoder bus that joins the host and device ends.
`default_nettype none
module cad_bus_sva
    import cad_pkg::*;
(
    input wire logic core_clk, // System clock.
    input wire logic rst_n, // Asynchronous reset, active low.
    input wire logic [15:0] addr, // Bus address.
    input wire logic [7:0] wdata, // Bus write data.
    input wire logic rd, // Read strobe.
    input wire logic wr, // Write strobe.
    input wire logic bank1, // Page select level.
    input wire logic bank2, // Layout select level.
    input wire logic [7:0] rdata, // Read data.
    input wire logic ack // Transfer acknowledge.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic first;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Marks the first edge after each reset release.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            first <= 1'b1;
        end else begin
            first <= 1'b0;
        end
    end
    sequence s_strobe;
        rd || wr;
    endsequence
    sequence s_status_rd;
        rd && addr == CAD_IRQ_STATUS;
    endsequence
    a_ack_after_strobe: assert property (s_strobe |=> ack)
        else $error("No ack one cycle after strobe");
    a_ack_needs_strobe: assert property (ack |-> $past(rd) || $past(wr))
        else $error("Ack without strobe");
    a_strobe_single: assert property (s_strobe |=> !(rd || wr))
        else $error("Strobe longer than one cycle");
    a_rdata_holds: assert property (!rd |=> $stable(rdata))
        else $error("Read data moved without a read");
    a_status_banks: assert property (s_status_rd |=>
        rdata[5:4] == {$past(bank1), $past(bank2)})
        else $error("Status bank bits wrong");
    a_status_reserved: assert property (s_status_rd |=> rdata[3:1] == 3'h0)
        else $error("Status reserved bits set");
    a_unused_zero: assert property (rd && addr inside {[16'h740B:16'h740E]} |=>
        rdata == 8'h00)
        else $error("Unused address read not zero");
    a_reserved_zero: assert property (rd && addr inside {[16'h7440:16'h75FE]} |=>
        rdata == 8'h00)
        else $error("Reserved address read not zero");
    a_bank_reset: assert property (first |-> bank1 && !bank2)
        else $error("Bank levels wrong after reset");
endmodule
`default_nettype wire

// ### tb/controller_address_decode_io_tb_top.sv
// Self-checking bench: AHB traffic into the host end, decoder end observed.
`default_nettype none
module controller_address_decode_io_tb_top
    import cad_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] AMAP [18] = '{16'h0000, 16'h1FFF, 16'h2000, 16'h5FFF, 16'h6000,
        16'h6FFF, 16'h7000, 16'h705F, 16'h7060, 16'h73FF, 16'h7400, 16'h75FF, 16'h7600,
        16'h7FF7, 16'h7FF8, 16'h7FFF, 16'h8000, 16'hFFFF};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic [31:0] hrdata;
    logic [63:0] in_pin_n = '1;
    logic [7:0] ext_rdata = 8'h3C;
    logic [7:0] dta_minutes = 8'h2B;
    logic [7:0] downtime_seconds = 8'h19;
    logic acc_overflow = 1'b0;
    logic uart_irq = 1'b0;
    logic rtc_irq = 1'b0;
    cad_region_e mem_region;
    logic [16:0] prom_addr;
    logic [3:0] uart_sel;
    logic [2:0] uart_reg;
    logic rtc_sel, rtc_reset, orient_restart, dta_clear;
    logic [79:0] out_pin_o, out_pin_oe;
    logic [31:0] r;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    int n_orient = 0;
    int n_clear = 0;
    int n_rtc = 0;
    cad_bus_if bus ();
    cad_host u_cad_host (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hready), .hresp(), .bus(bus));
    cad_dev u_cad_dev (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .in_pin_n(in_pin_n),
        .ext_rdata(ext_rdata), .dta_minutes(dta_minutes), .downtime_seconds(downtime_seconds),
        .acc_overflow(acc_overflow), .uart_irq(uart_irq), .rtc_irq(rtc_irq),
        .mem_region(mem_region), .prom_addr(prom_addr), .uart_sel(uart_sel),
        .uart_reg(uart_reg), .rtc_sel(rtc_sel), .rtc_reset(rtc_reset),
        .orient_restart(orient_restart), .dta_clear(dta_clear), .out_pin_o(out_pin_o),
        .out_pin_oe(out_pin_oe));
    cad_bus_sva u_cad_bus_sva (.core_clk(core_clk), .rst_n(rst_n), .addr(bus.addr),
        .wdata(bus.wdata), .rd(bus.rd), .wr(bus.wr), .bank1(bus.bank1), .bank2(bus.bank2),
        .rdata(bus.rdata), .ack(bus.ack));
    always #2.5 core_clk = ~core_clk;
    // The whole run needs a little over a thousand cycles, so this ceiling only trips on a hang.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        n_orient += int'(orient_restart === 1'b1);
        n_clear += int'(dta_clear === 1'b1);
        n_rtc += int'(rtc_reset === 1'b1);
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic complete_run;
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hready !== 1'b1);
        r = hrdata;
    endtask
    // One decoder bus transfer; the read byte is left in r[15:8].
    task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d);
        int i;
        ahb(1'b1, CAD_HR_ADDR, {16'h0, a});
        ahb(1'b1, CAD_HR_WDATA, {24'h0, d});
        ahb(1'b1, CAD_HR_CTRL, {30'h0, w, 1'b1});
        i = 0;
        do begin
            ahb(1'b0, CAD_HR_STATUS, 32'h0);
            i++;
        end while (r[1:0] !== 2'b10 && i < 50);
        check(32'(i < 50), 32'h1);
    endtask
    task automatic t_reset;
        check(32'(out_pin_oe != '0), 32'h0);
        ahb(1'b0, CAD_HR_BANK, 32'h0);
        check(r & 32'h3, 32'h1);
        op(1'b0, CAD_IRQ_STATUS, 8'h00);
        check(32'(r[15:8]), 32'h20);
    endtask
    task automatic t_map;
        logic [15:0] a;
        cad_region_e e;
        for (int b = 0; b < 4; b++) begin
            ahb(1'b1, CAD_HR_BANK, 32'(b));
            for (int i = 0; i < 18; i++) begin
                a = AMAP[i];
                op(1'b0, a, 8'h00);
                e = (a >= 16'h8000) ? CAD_RG_PROM : (a <= 16'h1FFF || a >= 16'h7600 ||
                    a inside {[16'h6000:16'h6FFF]}) ? CAD_RG_NVRAM : (a <= 16'h5FFF) ?
                    (b[1] ? CAD_RG_NVRAM : CAD_RG_PROM) : (a <= 16'h705F) ? CAD_RG_MCU :
                    (a <= 16'h73FF) ? CAD_RG_CPU_RAM : CAD_RG_IO;
                check(32'(mem_region), 32'(e));
                if (e == CAD_RG_PROM) begin
                    check(32'(prom_addr), {15'h0, b[0], a});
                end
                if (e != CAD_RG_IO) begin
                    check(32'(r[15:8]), 32'(ext_rdata));
                end
                check(32'(rtc_sel), 32'(a inside {[16'h7FF8:16'h7FFF]}));
            end
        end
        for (int k = 0; k < 4; k++) begin
            op(1'b0, CAD_UART_BASE + 16'(8 * k + 5), 8'h00);
            check(32'({uart_sel, 1'b0, uart_reg}), 32'({4'(1 << k), 4'h5}));
        end
    endtask
    task automatic t_ports;
        for (int p = 0; p < 10; p++) begin
            op(1'b1, CAD_PORT_FIRST + 16'(p), 8'hA5 ^ 8'(p * 13));
        end
        op(1'b1, 16'h740B, 8'hFF);
        op(1'b1, 16'h7500, 8'hFF);
        op(1'b0, 16'h740C, 8'h00);
        op(1'b0, 16'h7500, 8'h00);
        check(32'(r[15:8]), 32'h0);
        op(1'b1, 16'h7403, 8'h00);
        for (int p = 0; p < 10; p++) begin
            check(32'(out_pin_oe[8*p+:8]), 32'(p == 2 ? 8'h00 : 8'hA5 ^ 8'(p * 13)));
        end
        check(32'(out_pin_o != '0), 32'h0);
        // A reset in mid-run must open every pin again.
        rst_n <= 1'b0;
        @(posedge core_clk);
        check(32'(out_pin_oe != '0), 32'h0);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask
    task automatic t_io;
        int n0, n1, n2;
        logic [7:0] v;
        for (int k = 1; k <= 8; k++) begin
            v = 8'h81 ^ 8'(k * 17);
            in_pin_n <= ~(64'(v) << (8 * (k - 1)));
            n0 = n_orient;
            op(1'b0, 16'h7400 + 16'(k), 8'h00);
            check(32'(r[15:8]), 32'(v));
            check(32'(n_orient - n0), 32'(k == 4));
        end
        n1 = n_clear;
        n2 = n_rtc;
        op(1'b0, CAD_DTA_MIN, 8'h00);
        check(32'(r[15:8]), 32'(dta_minutes));
        op(1'b0, CAD_DTA_SEC, 8'h00);
        check(32'(r[15:8]), 32'(downtime_seconds));
        op(1'b1, CAD_DTA_MIN, 8'h00);
        check(32'(n_clear - n1), 32'h1);
        for (int i = 0; i < 8; i++) begin
            uart_irq <= i[0];
            acc_overflow <= i[1];
            rtc_irq <= i[2];
            ahb(1'b1, CAD_HR_BANK, 32'(i[1:0]));
            op(1'b0, CAD_IRQ_STATUS, 8'h00);
            check(32'(r[15:8]), 32'({i[2], i[1], i[0], i[1], 3'h0, i[0]}));
            check(32'({bus.bank2, bus.bank1}), 32'(i[1:0]));
        end
        check(32'(n_rtc - n2), 32'h0);
        op(1'b1, CAD_IRQ_STATUS, 8'h00);
        check(32'(n_rtc - n2), 32'h1);
    endtask
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_map();
        t_ports();
        t_io();
        complete_run();
    end
endmodule
`default_nettype wire
